// ---- include/accel_req_pkg.sv ----
/*
  Constants for the acceleration request decoder: command word fields,
  response words and frame counts.
  Assumes a 16-bit SPI command word, MSB first.
*/
`default_nettype none

package accel_req_pkg;

  // ----------------------------------------------------------------
  // Frame
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS = 16;
  localparam logic [4:0]  LAST_BIT  = 5'h0F;
  localparam logic [4:0]  OVER_BIT  = 5'h10;
  localparam logic [4:0]  CNT_SAT   = 5'h11;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int unsigned CMD_ACCEL    = 15;
  localparam int unsigned CMD_AXIS     = 14;
  localparam int unsigned CMD_OCN      = 13;
  localparam int unsigned CMD_SIGNED   = 12;
  localparam int unsigned CMD_ZERO_HI  = 11;
  localparam int unsigned CMD_ZERO_LO  = 3;
  localparam int unsigned CMD_ARM      = 2;
  localparam int unsigned CMD_ADDR_HI  = 12;
  localparam int unsigned CMD_ADDR_LO  = 8;

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam int unsigned CFG_SIGNED   = 4;
  localparam int unsigned CFG_ARM_HI   = 2;
  localparam int unsigned CFG_ARM_LO   = 1;

  // ----------------------------------------------------------------
  // Response words, parity bit 12 filled in later except in RSP_BAD_REG and RSP_RESET
  // ----------------------------------------------------------------
  localparam int unsigned RSP_PARITY   = 12;
  localparam logic [1:0]  ST_NORMAL    = 2'h1;
  localparam logic [1:0]  ST_ERROR     = 2'h3;
  localparam logic [9:0]  DAT_ERR_SGN  = 10'h000;
  localparam logic [9:0]  DAT_ERR_UNS  = 10'h200;
  localparam logic [9:0]  DAT_SPI_ERR  = 10'h3FF;
  localparam logic [9:0]  DAT_BAD_ACC  = 10'h155;
  localparam logic [9:0]  DAT_INT_ERR  = 10'h0AA;
  localparam logic [15:0] RSP_BAD_REG  = 16'h0E00;
  localparam logic [15:0] RSP_RESET    = 16'h0EAA;

  typedef enum logic [1:0] {IDLE, FRAME, HOLD} frame_state_t;

endpackage

`default_nettype wire

// ---- logic/resp_buffer.sv ----
/*
  Small response FIFO with valid/ready on both sides.
  Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

module resp_buffer #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_fill;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_fill   = fill;
    if (push & ~pop) begin
      next_fill = fill + (AW+1)'(1);
    end else if (pop & ~push) begin
      next_fill = fill - (AW+1)'(1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

`default_nettype wire

// ---- logic/accel_spi_request.sv ----
/*
  SPI command decoder for acceleration data requests: receives the
  16-bit command on sclk, checks it on mclk and prepares the response
  word sent during the next frame.
  Assumes status flags, config and sample data come from mclk logic,
  and that cs_n falls at least three mclk periods before the first
  sclk edge of a frame.
*/
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Command bit 15 set means an acceleration data request.
// - Axis bit and active-low offset bit pick X/Y, cancelled or raw.
// - Signed expectation bit is compared with config bit 4.
// - Arming expectation bit is compared with config bit 2 OR bit 1.
// - Any expectation difference flags mismatch and withholds the sample.
// - Command word must have odd parity; device checks it.
// - Data only when status flags clear and no pending error.
// - All checks pass gives valid data, else top-priority error reply.
// - Mismatch answers invalid request once, no fault, no arming update.
// - Nonzero bits 3 to 11 of an acceleration request is SPI error.
// - Priority: SPI, output check, invalid, init, reset, CRC, self-test.
// - Bit 15 clear is register access; axis bit chooses read or write.
module accel_spi_request
  import accel_req_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = 2
) (
  // Clocks and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        sclk,
  // SPI pins
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  // Device state
  input  wire logic [7:0]  device_config_reg,
  input  wire logic        init_pending_flag,
  input  wire logic        reset_occurred_flag,
  input  wire logic        internal_fault_flag,
  input  wire logic        crc_error,
  input  wire logic        self_test_error,
  input  wire logic        miso_verify_error,
  // Samples
  input  wire logic [9:0]  x_offset_data,
  input  wire logic [9:0]  x_raw_data,
  input  wire logic [9:0]  y_offset_data,
  input  wire logic [9:0]  y_raw_data,
  // Register access
  output logic             reg_req,
  output logic             reg_write,
  output logic [4:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  input  wire logic [15:0] reg_resp_word,
  // Events
  output logic             accel_served,
  output logic             arm_update,
  output logic             mismatch_event,
  output logic             spi_error_event,
  output logic             resp_stall
);
  import accel_req_pkg::*;

  // --------------------------------------------------------------
  // Link side: receive shift, bit count, transmit select
  // --------------------------------------------------------------
  logic [4:0]  bit_cnt;
  logic [4:0]  next_bit_cnt;
  logic [14:0] rx_shift;
  logic [15:0] rx_word;
  logic        word_tog;
  logic        over_tog;
  logic        over_seen;
  logic        link_clr;
  logic [15:0] resp_hold;

  assign link_clr = sys_rst | cs_n;

  always_comb begin
    next_bit_cnt = (bit_cnt == CNT_SAT) ? bit_cnt : bit_cnt + 5'h01;
  end

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt   <= '0;
      over_seen <= 1'b0;
    end else begin
      bit_cnt   <= next_bit_cnt;
      over_seen <= over_seen | (bit_cnt == OVER_BIT);
    end
  end

  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_shift <= '0;
      rx_word  <= '0;
      word_tog <= 1'b0;
      over_tog <= 1'b0;
    end else begin
      rx_shift <= {rx_shift[13:0], mosi};
      if (bit_cnt == LAST_BIT) begin
        rx_word  <= {rx_shift, mosi};
        word_tog <= ~word_tog;
      end
      if ((bit_cnt == OVER_BIT) && !over_seen) begin
        over_tog <= ~over_tog;
      end
    end
  end

  assign miso_oe = ~cs_n;
  assign miso    = (!cs_n && bit_cnt < OVER_BIT) ?
                   resp_hold[4'hF - bit_cnt[3:0]] : 1'b0;

  // --------------------------------------------------------------
  // Crossings into mclk
  // --------------------------------------------------------------
  logic [3:0] meta;
  logic [3:0] sync;
  logic [3:0] prev;
  logic       cs_fall;
  logic       cs_rise;
  logic       word_ev;
  logic       over_ev;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 4'h1;
      sync <= 4'h1;
      prev <= 4'h1;
    end else begin
      meta <= {over_tog, word_tog, sclk, cs_n};
      sync <= meta;
      prev <= sync;
    end
  end

  assign cs_fall = prev[0] & ~sync[0];
  assign cs_rise = ~prev[0] & sync[0];
  assign word_ev = sync[2] ^ prev[2];
  assign over_ev = sync[3] ^ prev[3];

  // --------------------------------------------------------------
  // Response building
  // --------------------------------------------------------------
  function automatic logic odd_ok(input logic [15:0] w);
    odd_ok = ^w;
  endfunction

  function automatic logic [15:0] rsp(input logic [2:0] top,
                                      input logic [1:0] st,
                                      input logic [9:0] dat);
    logic [15:0] w;
    w = {top, 1'b0, st, dat};
    w[RSP_PARITY] = ~(^w);
    rsp = w;
  endfunction

  // --------------------------------------------------------------
  // Frame check and decision
  // --------------------------------------------------------------
  frame_state_t state;
  frame_state_t next_state;
  logic        got_word, next_got_word;
  logic        got_over, next_got_over;
  logic        frame_err, next_frame_err;
  logic [15:0] out_word, next_out_word;
  logic        out_valid, next_out_valid;
  logic        out_ready;
  logic        next_reg_req, next_reg_write;
  logic [4:0]  next_reg_addr;
  logic [7:0]  next_reg_wdata;
  logic        next_accel_served, next_arm_update;
  logic        next_mismatch_event, next_spi_error_event;
  logic        is_acc, spi_e, mism, sd_cfg, arm_cfg, fault;
  logic [9:0]  sample, err_dat;

  always_comb begin
    is_acc  = rx_word[CMD_ACCEL];
    sd_cfg  = device_config_reg[CFG_SIGNED];
    arm_cfg = device_config_reg[CFG_ARM_HI] | device_config_reg[CFG_ARM_LO];
    spi_e   = frame_err | sync[1] | ~(got_word | word_ev) |
              got_over | over_ev | ~odd_ok(rx_word) |
              (is_acc & (|rx_word[CMD_ZERO_HI:CMD_ZERO_LO]));
    mism    = is_acc & ((rx_word[CMD_SIGNED] != sd_cfg) |
                        (rx_word[CMD_ARM] != arm_cfg));
    fault   = init_pending_flag | reset_occurred_flag |
              internal_fault_flag | crc_error;
    err_dat = sd_cfg ? DAT_ERR_SGN : DAT_ERR_UNS;
    case ({rx_word[CMD_AXIS], rx_word[CMD_OCN]})
      2'b00:   sample = x_offset_data;
      2'b01:   sample = x_raw_data;
      2'b10:   sample = y_offset_data;
      default: sample = y_raw_data;
    endcase
    next_state           = state;
    next_got_word        = got_word | word_ev;
    next_got_over        = got_over | over_ev;
    next_frame_err       = frame_err;
    next_out_word        = out_word;
    next_out_valid       = out_valid;
    next_reg_req         = 1'b0;
    next_reg_write       = reg_write;
    next_reg_addr        = reg_addr;
    next_reg_wdata       = reg_wdata;
    next_accel_served    = 1'b0;
    next_arm_update      = 1'b0;
    next_mismatch_event  = 1'b0;
    next_spi_error_event = 1'b0;
    case (state)
      IDLE: begin
        if (cs_fall) begin
          next_state     = FRAME;
          next_got_word  = 1'b0;
          next_got_over  = 1'b0;
          next_frame_err = sync[1];
        end
      end
      FRAME: begin
        if (cs_rise) begin
          next_state           = HOLD;
          next_out_valid       = 1'b1;
          next_spi_error_event = spi_e;
          if (spi_e) begin
            next_out_word = rsp(3'b000, ST_ERROR, DAT_SPI_ERR);
          end else if (miso_verify_error) begin
            next_out_word = rsp(3'b000, ST_ERROR, err_dat);
            next_reg_req  = ~is_acc & rx_word[CMD_AXIS];
          end else if (!is_acc) begin
            next_reg_req  = 1'b1;
            next_out_word = reg_resp_word;
          end else if (mism) begin
            next_mismatch_event = 1'b1;
            next_out_word = rsp(3'b000, ST_ERROR, DAT_BAD_ACC);
          end else if (fault) begin
            next_out_word = rsp(3'b000, ST_ERROR, DAT_INT_ERR);
          end else if (self_test_error) begin
            next_out_word = rsp(3'b001, ST_ERROR, err_dat);
          end else begin
            next_accel_served = 1'b1;
            next_arm_update   = 1'b1;
            next_out_word = rsp({rx_word[CMD_OCN], 1'b0, rx_word[CMD_AXIS]},
                                ST_NORMAL, sample);
          end
          next_reg_write = rx_word[CMD_AXIS];
          next_reg_addr  = rx_word[CMD_ADDR_HI:CMD_ADDR_LO];
          next_reg_wdata = rx_word[7:0];
        end
      end
      HOLD: begin
        if (out_ready) begin
          next_out_valid = 1'b0;
          next_state     = IDLE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state           <= IDLE;
      got_word        <= 1'b0;
      got_over        <= 1'b0;
      frame_err       <= 1'b0;
      out_word        <= RSP_RESET;
      out_valid       <= 1'b0;
      reg_req         <= 1'b0;
      reg_write       <= 1'b0;
      reg_addr        <= '0;
      reg_wdata       <= '0;
      accel_served    <= 1'b0;
      arm_update      <= 1'b0;
      mismatch_event  <= 1'b0;
      spi_error_event <= 1'b0;
    end else begin
      state           <= next_state;
      got_word        <= next_got_word;
      got_over        <= next_got_over;
      frame_err       <= next_frame_err;
      out_word        <= next_out_word;
      out_valid       <= next_out_valid;
      reg_req         <= next_reg_req;
      reg_write       <= next_reg_write;
      reg_addr        <= next_reg_addr;
      reg_wdata       <= next_reg_wdata;
      accel_served    <= next_accel_served;
      arm_update      <= next_arm_update;
      mismatch_event  <= next_mismatch_event;
      spi_error_event <= next_spi_error_event;
    end
  end

  // --------------------------------------------------------------
  // Response buffer and transmit hold
  // --------------------------------------------------------------
  logic        buf_valid;
  logic        buf_pop;
  logic [15:0] buf_data;
  logic [15:0] next_resp_hold;

  resp_buffer #(
    .WIDTH (WORD_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_resp_buffer (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (out_valid),
    .in_ready  (out_ready),
    .in_data   (out_word),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  assign buf_pop    = buf_valid & sync[0] & (state == IDLE);
  assign resp_stall = out_valid & ~out_ready;

  always_comb begin
    next_resp_hold = buf_pop ? buf_data : resp_hold;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_hold <= RSP_RESET;
    end else begin
      resp_hold <= next_resp_hold;
    end
  end

endmodule

`default_nettype wire

// ---- test/accel_spi_request_assertions.sv ----
/*
  Port checker for accel_spi_request, event and gating relations.
  Assumes it is bound to the design top and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none

module accel_spi_request_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Pins and device state
  input wire logic cs_n,
  input wire logic init_pending_flag,
  input wire logic reset_occurred_flag,
  input wire logic internal_fault_flag,
  input wire logic crc_error,
  input wire logic self_test_error,
  input wire logic miso_verify_error,
  // Events
  input wire logic reg_req,
  input wire logic accel_served,
  input wire logic arm_update,
  input wire logic mismatch_event,
  input wire logic spi_error_event
);
  logic any_flag;

  always_comb any_flag = init_pending_flag | reset_occurred_flag |
    internal_fault_flag | crc_error | self_test_error | miso_verify_error;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_arm_pair; accel_served == arm_update; endproperty
  property p_mis_excl;
    mismatch_event |-> !accel_served && !arm_update && !spi_error_event;
  endproperty
  property p_mis_once; mismatch_event |=> !mismatch_event; endproperty
  property p_spi_excl;
    spi_error_event |-> !accel_served && !reg_req && !mismatch_event;
  endproperty
  property p_gate; accel_served |-> !$past(any_flag); endproperty
  property p_after;
    (accel_served || mismatch_event || spi_error_event || reg_req)
      |-> cs_n && $past(cs_n, 2);
  endproperty
  property p_reg_excl; reg_req |-> !accel_served && !mismatch_event;
  endproperty
  property p_srv_once; accel_served |=> !accel_served; endproperty

  a_arm_pair: assert property (p_arm_pair)
    else $error("arm update differs from served");
  a_mis_excl: assert property (p_mis_excl)
    else $error("mismatch with other event");
  a_mis_once: assert property (p_mis_once)
    else $error("mismatch pulse too long");
  a_spi_excl: assert property (p_spi_excl)
    else $error("spi error with other event");
  a_gate: assert property (p_gate)
    else $error("data served with a flag set");
  a_after: assert property (p_after)
    else $error("event while frame open");
  a_reg_excl: assert property (p_reg_excl)
    else $error("register access with accel event");
  a_srv_once: assert property (p_srv_once)
    else $error("served pulse too long");

  c_served: cover property (accel_served);
  c_mismatch: cover property (mismatch_event);
  c_spi: cover property (spi_error_event);
endmodule

bind accel_spi_request accel_spi_request_assertions u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n),
  .init_pending_flag(init_pending_flag),
  .reset_occurred_flag(reset_occurred_flag),
  .internal_fault_flag(internal_fault_flag), .crc_error(crc_error),
  .self_test_error(self_test_error), .miso_verify_error(miso_verify_error),
  .reg_req(reg_req), .accel_served(accel_served), .arm_update(arm_update),
  .mismatch_event(mismatch_event), .spi_error_event(spi_error_event));

`default_nettype wire

// ---- test/spi_master_model.sv ----
/*
  SPI master model: one 16-bit frame per call, sclk 30 ns in frames.
  Assumes the device answers in the following frame, MSB first.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_master_model (
  // SPI pins
  output logic     sclk,
  output logic     cs_n,
  output logic     mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // ---------------------------------------------------------------
  // Frame: sample miso, then raise sclk; sclk stands low outside
  // ---------------------------------------------------------------
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    #7;
    cs_n = 1'b0;
    #70;
    for (int i = 15; i >= 0; i--) begin
      mosi = cmd[i];
      #15;
      rsp[i] = miso;
      sclk = 1'b1;
      #15;
      sclk = 1'b0;
    end
    #70;
    cs_n = 1'b1;
    mosi = ~mosi;
    #300;
  endtask
endmodule

`default_nettype wire

// ---- test/tb.sv ----
/*
  Testbench for accel_spi_request: frames through the master model.
  Assumes the reply to each command arrives in the next frame.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        mclk, sys_rst, sclk, cs_n, mosi, miso, miso_oe;
  logic [7:0]  cfg;
  logic [5:0]  flg;
  logic [9:0]  samp [4];
  logic [15:0] rreg, pend;
  logic        reg_req, reg_write, accel_served, arm_update;
  logic        mismatch_event, spi_error_event, resp_stall;
  logic [4:0]  reg_addr, ev_seen;
  logic        ev_clr;
  logic [7:0]  reg_wdata;
  logic [13:0] cap;
  int          n_fail, total_checks;

  accel_spi_request DUT (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .device_config_reg(cfg), .init_pending_flag(flg[0]),
    .reset_occurred_flag(flg[1]), .internal_fault_flag(flg[2]),
    .crc_error(flg[3]), .self_test_error(flg[4]),
    .miso_verify_error(flg[5]), .x_offset_data(samp[0]),
    .x_raw_data(samp[1]), .y_offset_data(samp[2]), .y_raw_data(samp[3]),
    .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_resp_word(rreg),
    .accel_served(accel_served), .arm_update(arm_update),
    .mismatch_event(mismatch_event), .spi_error_event(spi_error_event),
    .resp_stall(resp_stall));

  spi_master_model m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (ev_clr)
      ev_seen <= '0;
    else
      ev_seen <= ev_seen | {reg_req, spi_error_event, mismatch_event,
                            arm_update, accel_served};
    if (reg_req) cap <= {reg_write, reg_addr, reg_wdata};
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] odd(input logic [15:0] w, input int p);
    w[p] = 1'b0;
    w[p] = ~^w;
    return w;
  endfunction
  function automatic logic [15:0] acmd(input logic ax, ocn, sd, arm);
    return odd({1'b1, ax, ocn, sd, 9'h000, arm, 2'b00}, 0);
  endfunction
  function automatic logic [15:0] vrsp(input logic ax, ocn);
    return odd({ocn, 1'b0, ax, 1'b0, 2'b01, samp[{ax, ocn}]}, 12);
  endfunction
  function automatic logic [15:0] ersp(input logic [2:0] h,
                                       input logic [9:0] d);
    return odd({h, 1'b0, 2'b11, d}, 12);
  endfunction

  task automatic chk(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic set(input logic [7:0] c, input logic [5:0] f);
    @(posedge mclk);
    cfg <= c;
    flg <= f;
    @(posedge mclk);
  endtask
  task automatic send(input logic [15:0] c, e, input logic [4:0] ev);
    logic [15:0] r;
    @(posedge mclk);
    ev_clr <= 1'b1;
    @(posedge mclk);
    ev_clr <= 1'b0;
    m.xfer(c, r);
    chk({11'h000, ev_seen}, {11'h000, ev});
    chk({14'h0000, miso_oe, resp_stall}, 16'h0000);
    chk(r, pend);
    pend = e;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_modes;
    for (int k = 0; k < 4; k++)
      send(acmd(k[1], k[0], 1'b0, 1'b0), vrsp(k[1], k[0]), 5'h03);
  endtask
  task automatic t_cfg;
    logic [10:0] t [6] = '{{8'h10, 3'b101}, {8'h10, 3'b000},
      {8'h00, 3'b100}, {8'h04, 3'b011}, {8'h02, 3'b011}, {8'h06, 3'b000}};
    for (int i = 0; i < 6; i++) begin
      set(t[i][10:3], 6'h00);
      if (t[i][0])
        send(acmd(1'b0, 1'b1, t[i][2], t[i][1]), vrsp(1'b0, 1'b1), 5'h03);
      else
        send(acmd(1'b0, 1'b1, t[i][2], t[i][1]), ersp(3'h0, 10'h155), 5'h04);
    end
  endtask
  task automatic t_spi;
    set(8'h10, 6'h3F);
    send(acmd(1'b0, 1'b0, 1'b0, 1'b0) ^ 16'h0001, ersp(3'h0, 10'h3FF), 5'h08);
    for (int b = 3; b <= 11; b += 8)
      send(acmd(1'b0, 1'b0, 1'b0, 1'b0) ^ (16'h0001 | (16'h0001 << b)),
           ersp(3'h0, 10'h3FF), 5'h08);
  endtask
  task automatic t_gate;
    logic [19:0] t [9] = '{{3'h0, 10'h0AA, 7'h01}, {3'h0, 10'h0AA, 7'h02},
      {3'h0, 10'h0AA, 7'h04}, {3'h0, 10'h0AA, 7'h08},
      {3'h1, 10'h200, 7'h10}, {3'h0, 10'h200, 7'h20},
      {3'h0, 10'h200, 7'h30}, {3'h0, 10'h0AA, 7'h11},
      {3'h0, 10'h155, 7'h41}};
    for (int i = 0; i < 9; i++) begin
      set(8'h00, t[i][5:0]);
      send(acmd(1'b0, 1'b0, t[i][6], 1'b0), ersp(t[i][19:17], t[i][16:7]),
           t[i][6] ? 5'h04 : 5'h00);
    end
    set(8'h00, 6'h00);
  endtask
  task automatic t_reg;
    send(odd({3'b010, 5'h0B, 8'hA5}, 13), rreg, 5'h10);
    chk({2'b00, cap}, {3'b001, 5'h0B, 8'hA5});
    send(odd({3'b000, 5'h03, 8'h00}, 13), rreg, 5'h10);
    chk({2'b00, cap}, {3'b000, 5'h03, 8'h00});
  endtask

  initial begin
    sys_rst = 1'b1;
    ev_clr = 1'b0;
    cfg = 8'h00;
    flg = 6'h00;
    rreg = 16'h5C3A;
    samp = '{10'h123, 10'h2C5, 10'h05A, 10'h3A1};
    pend = 16'h0EAA;
    n_fail = 0;
    total_checks = 0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_modes;
    t_cfg;
    t_spi;
    t_gate;
    t_reg;
    send(acmd(1'b0, 1'b0, 1'b0, 1'b0), 16'h0000, 5'h03);
    test_done;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    test_done;
  end
endmodule

`default_nettype wire
